// *** verilog/hppc_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module hppc_top #(
    parameter int ADDR_W = 16
) (
    input  wire logic              i_core_clk,
    input  wire logic              i_rst,
    input  wire logic              i_port_module_strap,
    input  wire logic              i_wide_mode_strap,
    input  wire logic              i_output_off_n,
    input  wire logic              i_port_select_n,
    input  wire logic              i_data_strobe_a_n,
    input  wire logic              i_data_strobe_b_n,
    input  wire logic              i_addr_strobe_n,
    input  wire logic              i_host_direction,
    input  wire logic              i_reg_select_bit0,
    input  wire logic              i_reg_select_bit1,
    input  wire logic              i_byte_half_id,
    input  wire logic [ADDR_W-1:0] i_addr_bus,
    input  wire logic              i_irq_request,
    input  wire logic              i_engine_done,
    output var  logic              o_port_ready,
    output var  logic              o_port_ready_oe,
    output var  logic              o_host_irq_n,
    output var  logic              o_host_irq_oe,
    output var  logic              o_holders_en,
    output var  logic              o_module_active,
    output var  logic              o_wide_mode,
    output var  logic              o_xfer_start,
    output var  logic              o_xfer_read,
    output var  logic [1:0]        o_xfer_reg,
    output var  logic              o_xfer_second,
    output var  logic [ADDR_W-1:0] o_port_address_register
);
    hppc_strap_if strap ();

    // strap capture lives apart so the top only sees stable levels
    hppc_strap_latch u_strap (
        .i_core_clk          (i_core_clk),
        .i_rst               (i_rst),
        .i_port_module_strap (i_port_module_strap),
        .i_wide_mode_strap   (i_wide_mode_strap),
        .strap               (strap)
    );

    typedef enum logic [1:0] {
        HPPC_IDLE,   // waiting for a strobe
        HPPC_ACTIVE, // strobe low, access in progress
        HPPC_BUSY    // strobe gone, engine still working
    } hppc_state_e;

    typedef struct packed {
        hppc_state_e       state;
        logic              strobe_q;   // previous combined strobe
        logic              astb_q;     // previous address strobe
        logic [7:0]        busy_cnt;   // cycles left before ready
        logic              ready;
        logic              ready_oe;
        logic              irq_n;
        logic              irq_oe;
        logic              holders;
        logic              active;
        logic              wide;
        logic              start;
        logic              rd;
        logic [1:0]        regsel;
        logic              second;
        logic [ADDR_W-1:0] addr;
    } hppc_top_s;

    hppc_top_s s_q;
    hppc_top_s s_d;

    logic strobe_act;   // combined strobe, active high
    logic astb_act;     // address strobe, active high
    logic en;           // module usable

    // either strobe low with select low starts a cycle
    // both strobes low cancel out, so a host driving both is ignored
    always_comb begin
        en         = strap.valid && strap.port_en;
        strobe_act = !i_port_select_n && en &&
                     (!i_data_strobe_a_n ^ !i_data_strobe_b_n);
        astb_act   = !i_port_select_n && en && !i_addr_strobe_n;
    end

    // single next-state process for the whole port
    always_comb begin
        s_d          = s_q;
        s_d.start    = 1'b0;
        s_d.strobe_q = strobe_act;
        s_d.astb_q   = astb_act;
        s_d.active   = en;
        s_d.holders  = strap.valid && !strap.port_en;
        s_d.wide     = strap.valid && strap.port_en && strap.wide;
        // outputs float together with output-off
        s_d.ready_oe = i_output_off_n && en;
        // irq unused in wide mode, so not driven there
        s_d.irq_oe   = i_output_off_n && en && !strap.wide;
        s_d.irq_n    = !(i_irq_request && en && !strap.wide);
        // falling address strobe latches the multiplexed address
        if (astb_act && !s_q.astb_q) begin
            s_d.addr = i_addr_bus;
        end
        unique case (s_q.state)
            HPPC_IDLE: begin
                s_d.ready = en;
                if (strobe_act && !s_q.strobe_q) begin
                    s_d.state  = HPPC_ACTIVE;
                    s_d.start  = 1'b1;
                    s_d.ready  = 1'b0;
                    s_d.rd     = (i_host_direction == hppc_pkg::DIR_READ);
                    // wide mode has no register select or byte halves
                    if (strap.wide) begin
                        s_d.regsel = hppc_pkg::SEL_DINC;
                        s_d.second = 1'b0;
                    end else begin
                        s_d.regsel = {i_reg_select_bit1,
                                      i_reg_select_bit0};
                        s_d.second = i_byte_half_id;
                    end
                end
            end
            HPPC_ACTIVE: begin
                // strobe release ends the host cycle
                if (!strobe_act) begin
                    s_d.state    = HPPC_BUSY;
                    s_d.busy_cnt = 8'(hppc_pkg::BUSY_CYCLES);
                end
            end
            HPPC_BUSY: begin
                // ready comes back only after engine and minimum delay
                if (s_q.busy_cnt != 8'h00) begin
                    s_d.busy_cnt = s_q.busy_cnt - 8'h01;
                end else if (i_engine_done) begin
                    s_d.state = HPPC_IDLE;
                    s_d.ready = en;
                end
            end
            // the fourth code is never entered; recover to idle if it is
            default: begin
                s_d.state = HPPC_IDLE;
            end
        endcase
    end

    // async reset takes constants only
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            s_q       <= '0;
            s_q.state <= HPPC_IDLE;
            s_q.ready <= hppc_pkg::RST_READY;
            s_q.irq_n <= hppc_pkg::RST_IRQ_N;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_port_ready            = s_q.ready;
    assign o_port_ready_oe         = s_q.ready_oe;
    assign o_host_irq_n            = s_q.irq_n;
    assign o_host_irq_oe           = s_q.irq_oe;
    assign o_holders_en            = s_q.holders;
    assign o_module_active         = s_q.active;
    assign o_wide_mode             = s_q.wide;
    assign o_xfer_start            = s_q.start;
    assign o_xfer_read             = s_q.rd;
    assign o_xfer_reg              = s_q.regsel;
    assign o_xfer_second           = s_q.second;
    assign o_port_address_register = s_q.addr;

    // a start always drops ready
    AST_START_NOT_READY: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        s_q.start |-> !s_q.ready)
        else $error("ready high at transfer start");
    // select high means no new transfer
    AST_SELECT_GATES: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        i_port_select_n |=> !s_q.start)
        else $error("transfer started while deselected");
    // ready floats one cycle after output-off goes low
    AST_READY_FLOAT: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        !i_output_off_n |=> !o_port_ready_oe)
        else $error("ready driven while output-off low");
    // irq floats on the same terms as ready
    AST_IRQ_FLOAT: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        !i_output_off_n |=> !o_host_irq_oe)
        else $error("irq driven while output-off low");
    // wide mode forces the data register code
    AST_WIDE_SEL: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (s_q.start && s_q.wide) |-> s_q.regsel == hppc_pkg::SEL_DINC)
        else $error("select bits used in wide mode");
    // direction level is taken with the strobe
    AST_DIR: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (strobe_act && !s_q.strobe_q && s_q.state == HPPC_IDLE)
        |=> s_q.rd == $past(i_host_direction))
        else $error("direction not captured");
    // falling address strobe loads the address register
    AST_ADDR: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (astb_act && !s_q.astb_q) |=> s_q.addr == $past(i_addr_bus))
        else $error("address not latched");
    // without an address strobe edge the register keeps its value
    AST_ADDR_HOLD: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        !(astb_act && !s_q.astb_q) |=> $stable(s_q.addr))
        else $error("address register changed without strobe");
    // a deselected module neither starts nor reports ready
    AST_NO_MODULE: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        !en |=> !s_q.start && !s_q.ready)
        else $error("deselected module responded");
    // deselected by strap: holders on, module idle
    AST_HOLDERS: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (strap.valid && !strap.port_en) |=> o_holders_en && !o_module_active)
        else $error("holders not set for deselected module");
    // wide mode flag only follows a high mode strap
    AST_WIDE_STRAP: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        o_wide_mode |-> strap.wide && en)
        else $error("wide mode without its strap");
    // the minimum busy time after a strobe release
    AST_BUSY_MIN: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (s_q.state == HPPC_ACTIVE && !strobe_act) |=> !s_q.ready [*4])
        else $error("ready returned too early");
    // busy counter steps down by one each cycle
    AST_BUSY_COUNT: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (s_q.state == HPPC_BUSY && s_q.busy_cnt != 8'h00)
        |=> s_q.busy_cnt == $past(s_q.busy_cnt) - 8'h01)
        else $error("busy counter skipped");
    // ready stays low for the whole host cycle
    AST_ACTIVE_NOT_READY: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        s_q.state == HPPC_ACTIVE |-> !s_q.ready)
        else $error("ready high during an access");
    // counter spent and engine done gives ready back
    AST_READY_BACK: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (s_q.state == HPPC_BUSY && s_q.busy_cnt == 8'h00 &&
         i_engine_done && en) |=> s_q.ready)
        else $error("ready not returned after busy time");
    // a fresh strobe in idle is taken on the next edge
    AST_STROBE_TAKEN: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (strobe_act && !s_q.strobe_q && s_q.state == HPPC_IDLE)
        |=> s_q.start)
        else $error("strobe not taken");
    // start is a single-cycle pulse
    AST_START_PULSE: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        s_q.start |=> !s_q.start)
        else $error("start longer than one cycle");
    // byte mode takes the select bits as given
    AST_REG_DECODE: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (strobe_act && !s_q.strobe_q && s_q.state == HPPC_IDLE &&
         !strap.wide)
        |=> s_q.regsel == $past({i_reg_select_bit1, i_reg_select_bit0}))
        else $error("register select not decoded");
    // byte mode forwards the half id with the access
    AST_HALF_ID: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (strobe_act && !s_q.strobe_q && s_q.state == HPPC_IDLE &&
         !strap.wide)
        |=> s_q.second == $past(i_byte_half_id))
        else $error("byte half id not forwarded");
    // wide mode has no second half
    AST_WIDE_HALF: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (s_q.start && s_q.wide) |-> !s_q.second)
        else $error("half id used in wide mode");
    // ready pin driven whenever output-off is high and the module is enabled
    AST_READY_DRIVEN: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (i_output_off_n && en) |=> o_port_ready_oe)
        else $error("ready pin left floating");
    // irq idle and undriven in wide mode
    AST_IRQ_WIDE: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        strap.wide |=> !o_host_irq_oe && o_host_irq_n)
        else $error("irq used in wide mode");
    // a core request pulls irq low in byte mode
    AST_IRQ_DRIVE: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (en && !strap.wide && i_irq_request) |=> !o_host_irq_n)
        else $error("irq request not passed on");

    COV_READ: cover property (@(posedge i_core_clk) s_q.start && s_q.rd);
    COV_WRITE: cover property (@(posedge i_core_clk) s_q.start && !s_q.rd);
    COV_WIDE: cover property (@(posedge i_core_clk) s_q.start && s_q.wide);
    COV_ADDR: cover property (@(posedge i_core_clk) astb_act && !s_q.astb_q);
    COV_BUSY_WAIT: cover property (@(posedge i_core_clk)
        s_q.state == HPPC_BUSY && s_q.busy_cnt == 8'h00 && !i_engine_done);
endmodule
`default_nettype wire

// *** verilog/hppc_pkg.sv ***
`default_nettype none
package hppc_pkg;
    // register select codes of the three port registers
    localparam logic [1:0] SEL_CTRL = 2'h0;  // control register
    localparam logic [1:0] SEL_DINC = 2'h1;  // data, auto-increment
    localparam logic [1:0] SEL_ADDR = 2'h2;  // address register
    localparam logic [1:0] SEL_DFIX = 2'h3;  // data, fixed address
    // direction input levels
    localparam logic       DIR_READ  = 1'b1;
    localparam logic       DIR_WRITE = 1'b0;
    // internal ready latency after a strobe ends, in ns and cycles
    localparam int         CLK_PERIOD_NS   = 10;
    localparam int         BUSY_TIME_NS    = 40;
    localparam int         BUSY_CYCLES     =
        (BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // reset values
    localparam logic       RST_IRQ_N = 1'b1;
    localparam logic       RST_READY = 1'b0;
    // access kinds seen by the transfer engine
    typedef enum logic [1:0] {
        HPPC_ACC_CTRL,
        HPPC_ACC_ADDR,
        HPPC_ACC_DATA
    } hppc_acc_e;
endpackage
`default_nettype wire

// *** verilog/hppc_strap_if.sv ***
`timescale 1ns/100ps
`default_nettype none
// strap values caught at reset release, shared by the latch and the top
interface hppc_strap_if;
    logic port_en;   // module selected
    logic wide;      // sixteen-bit mode
    logic valid;     // straps captured since reset release
    modport latch (output port_en, output wide, output valid);
    modport user  (input port_en, input wide, input valid);
endinterface
`default_nettype wire

// *** verilog/hppc_strap_latch.sv ***
`timescale 1ns/100ps
`default_nettype none
// catches the straps on the first clock after reset release
module hppc_strap_latch (
    input  wire logic    i_core_clk,
    input  wire logic    i_rst,
    input  wire logic    i_port_module_strap,
    input  wire logic    i_wide_mode_strap,
    hppc_strap_if.latch  strap
);
    typedef struct packed {
        logic port_en;
        logic wide;
        logic valid;
    } hppc_strap_s;

    hppc_strap_s st_q;
    hppc_strap_s st_d;

    // sample once; hold until reset comes again
    always_comb begin
        st_d = st_q;
        if (!st_q.valid) begin
            st_d.port_en = i_port_module_strap;
            st_d.wide    = i_wide_mode_strap;
            st_d.valid   = 1'b1;
        end
    end

    // async reset to constants only; straps caught after release
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign strap.port_en = st_q.port_en;
    assign strap.wide    = st_q.wide;
    assign strap.valid   = st_q.valid;

    AST_STRAP_HOLD: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        $past(st_q.valid) |-> $stable({st_q.port_en, st_q.wide}))
        else $error("strap changed after capture");
endmodule
`default_nettype wire

// *** tb/hppc_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// behavioural host: changes its lines only at the falling edge
module hppc_host_model (
    input  wire logic        i_core_clk,
    input  wire logic        i_port_ready,
    output var  logic        o_sel_n,
    output var  logic        o_stb_a_n,
    output var  logic        o_stb_b_n,
    output var  logic        o_as_n,
    output var  logic        o_dir,
    output var  logic [1:0]  o_rs,
    output var  logic        o_half,
    output var  logic [15:0] o_addr
);
    initial begin
        {o_sel_n, o_stb_a_n, o_stb_b_n, o_as_n} = 4'hF;
        {o_dir, o_rs, o_half, o_addr} = 20'h0;
    end
    // one data transfer; sel_hi leaves the port unselected
    task automatic access(input logic dir, input logic [1:0] rs,
        input logic half, input logic sel_hi, input logic use_b,
        input int hold);
        // no new access before ready, bounded so a dead port still ends
        for (int i = 0; i < 50 && i_port_ready !== 1'b1; i++)
            @(negedge i_core_clk);
        o_sel_n = sel_hi;
        o_dir   = dir;
        o_rs    = rs;
        o_half  = half;
        @(negedge i_core_clk);
        if (use_b) o_stb_b_n = 1'b0;
        else o_stb_a_n = 1'b0;
        repeat (hold) @(negedge i_core_clk);
        o_stb_a_n = 1'b1;
        o_stb_b_n = 1'b1;
        @(negedge i_core_clk);
        o_sel_n = 1'b1;
        // released lines are not held: show the inverse of the last value
        o_dir   = ~dir;
        o_rs    = ~rs;
        o_half  = ~half;
    endtask
    // multiplexed-bus address phase
    task automatic latch_addr(input logic [15:0] a);
        @(negedge i_core_clk);
        o_sel_n = 1'b0;
        o_addr  = a;
        @(negedge i_core_clk);
        o_as_n  = 1'b0;
        @(negedge i_core_clk);
        o_as_n  = 1'b1;
        @(negedge i_core_clk);
        o_sel_n = 1'b1;
        o_addr  = ~a;
    endtask
endmodule
`default_nettype wire

// *** tb/hppc_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module hppc_bench;
    logic        clk, rst, en_s, wide_s, off_n, irq_req, done;
    logic        sel_n, sa_n, sb_n, as_n, dir, half;
    logic [1:0]  rs;
    logic [15:0] abus, rnd;
    logic        rdy, rdy_oe, irq_n, irq_oe, hold_en, act, wide;
    logic        st, x_rd, x_sec, c_rd, c_sec, c_rdy;
    logic [1:0]  x_reg, c_reg;
    logic [15:0] areg;
    int          failures, tests_run, starts, n0, cyc;
    hppc_top hppc_top_inst (.i_core_clk(clk), .i_rst(rst),
        .i_port_module_strap(en_s), .i_wide_mode_strap(wide_s),
        .i_output_off_n(off_n), .i_port_select_n(sel_n),
        .i_data_strobe_a_n(sa_n), .i_data_strobe_b_n(sb_n),
        .i_addr_strobe_n(as_n), .i_host_direction(dir),
        .i_reg_select_bit0(rs[0]), .i_reg_select_bit1(rs[1]),
        .i_byte_half_id(half), .i_addr_bus(abus),
        .i_irq_request(irq_req), .i_engine_done(done),
        .o_port_ready(rdy), .o_port_ready_oe(rdy_oe),
        .o_host_irq_n(irq_n), .o_host_irq_oe(irq_oe),
        .o_holders_en(hold_en), .o_module_active(act),
        .o_wide_mode(wide), .o_xfer_start(st), .o_xfer_read(x_rd),
        .o_xfer_reg(x_reg), .o_xfer_second(x_sec),
        .o_port_address_register(areg));
    hppc_host_model hppc_host_model_inst (.i_core_clk(clk),
        .i_port_ready(rdy), .o_sel_n(sel_n), .o_stb_a_n(sa_n),
        .o_stb_b_n(sb_n), .o_as_n(as_n), .o_dir(dir), .o_rs(rs),
        .o_half(half), .o_addr(abus));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // fixed-seed pseudo-random source
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // register code the port must report; wide mode forces data
    function automatic logic [1:0] exp_reg(input logic wide_m,
        input logic [1:0] rs_v);
        return wide_m ? hppc_pkg::SEL_DINC : rs_v;
    endfunction
    // engine finishes at random moments, so ready waits vary
    always @(negedge clk) begin
        rnd  <= lfsr(rnd);
        done <= rnd[3];
    end
    // catch each start pulse once it has settled
    always @(negedge clk) if (st === 1'b1) begin
        starts++;
        {c_rd, c_reg, c_sec, c_rdy} = {x_rd, x_reg, x_sec, rdy};
    end
    always @(posedge clk) if (++cyc == 30000) begin
        failures++;
        report_and_stop();
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        {failures, tests_run, starts, cyc} = '0;
        rnd = 16'h950A;
        {rst, done, irq_req, off_n} = 4'h9;
        for (int m = 0; m < 4; m++) begin
            @(negedge clk);
            rst    = 1'b1;
            en_s   = ~m[1];
            wide_s = m[0];
            repeat (20) @(negedge clk);
            chk(irq_n, 1'b1);
            rst = 1'b0;
            repeat (3) @(negedge clk);
            en_s   = ~en_s;
            wide_s = ~wide_s;
            repeat (3) @(negedge clk);
            chk(act, !m[1]);
            chk(hold_en, m[1]);
            if (!m[1]) chk(wide, m[0]);
            for (int k = 0; k < 7; k++) begin
                n0 = starts;
                hppc_host_model_inst.access(rnd[0], rnd[2:1], rnd[4],
                    k == 6, rnd[5], 1 + rnd[7:6]);
                if (!m[1]) for (int i = 0; i < 40 && rdy !== 1'b1; i++)
                    @(negedge clk);
                chk(16'(starts - n0), !m[1] && k != 6);
                if (!m[1] && k != 6) begin
                    chk(c_rdy, 1'b0);
                    chk(rdy, 1'b1);
                    chk(c_rd, !dir);
                    // released select lines show the inverse code
                    chk(c_reg, exp_reg(m[0], ~rs));
                    chk(c_sec, m[0] ? 1'b0 : !half);
                end
            end
            hppc_host_model_inst.latch_addr(rnd);
            repeat (2) @(negedge clk);
            if (!m[1]) chk(areg, ~abus);
            else chk(areg, 16'h0000);
            irq_req = 1'b1;
            repeat (3) @(negedge clk);
            chk(irq_oe, !m[1] && !m[0]);
            if (!m[1] && !m[0]) chk(irq_n, 1'b0);
            chk(rdy_oe, !m[1]);
            off_n = 1'b0;
            repeat (3) @(negedge clk);
            chk({rdy_oe, irq_oe}, 2'h0);
            off_n   = 1'b1;
            irq_req = 1'b0;
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
